/* acr_pkg.sv */
package acr_pkg;

    // register byte offsets
    localparam logic [7:0] ACR_CTRL_OFS    = 8'h00;
    localparam logic [7:0] ACR_GIE_OFS     = 8'h04;
    localparam logic [7:0] ACR_IER_OFS     = 8'h08;
    localparam logic [7:0] ACR_ISR_OFS     = 8'h0c;
    localparam logic [7:0] ACR_ARG_IN_OFS  = 8'h10;
    localparam logic [7:0] ACR_ARG_IHS_OFS = 8'h14;
    localparam logic [7:0] ACR_ARG_OUT_OFS = 8'h18;
    localparam logic [7:0] ACR_ARG_OHS_OFS = 8'h1c;
    localparam logic [7:0] ACR_WIDE_OFS    = 8'h20;
    localparam logic [7:0] ACR_PROCEED_OFS = 8'h28;
    localparam logic [7:0] ACR_PACK_OFS    = 8'h40;

    // array windows
    localparam int         ACR_PACK_WORDS  = 4;
    localparam int         ACR_PACK_ELEMS  = 8;
    localparam int         ACR_PACK_EW     = 8;
    localparam int         ACR_WIDE_WORDS  = 2;

    // control word fields
    localparam int ACR_LAUNCH_BIT  = 0;
    localparam int ACR_FINISH_BIT  = 1;
    localparam int ACR_IDLE_BIT    = 2;
    localparam int ACR_ACCEPT_BIT  = 3;
    localparam int ACR_RELAUNCH_BIT = 7;

    localparam int ACR_SRC_FINISH  = 0;
    localparam int ACR_SRC_ACCEPT  = 1;
    localparam int ACR_NUM_SRC     = 2;

    localparam logic [31:0] ACR_ARG_RST = 32'h0000_0000;

    // handshake flags for scalar operands
    typedef struct packed {
        logic valid;
        logic ack;
    } acr_hs_s;

    typedef struct packed {
        logic finish;
        logic idle;
        logic accept;
    } acr_status_s;

endpackage : acr_pkg

/* acr_ctrl_regs.sv */
`timescale 1ns/100ps
// Overview of operation
// - host write of launch bit drives core launch strobe
// - finish bit reads core finish flag (latched, cleared on read)
// - idle bit reads the core quiescent flag
// - accept-next bit reads the core accept-next flag
// - host write to proceed register pulses core proceed signal
// - self-relaunch bit relaunches core after each completion until cleared
// - input operand data register drives core input port
// - host write asserts input operand valid toward core
// - host write asserts output operand acknowledge toward core
// - output operand register returns core output value
// - host reads the output operand valid flag
// - host reads acknowledge the core returns for input operand
// - arrays occupy contiguous word window from base to top element
// - elements under 16 bits pack two per 32-bit word, one per half-word lane
// - elements over 32 bits span consecutive words
// - global enable gates interrupt output
// - interrupt logic exists with the launch strobe
// - two sources: 0 finish, 1 accept-next
// - per-source enables writable and readable
// - status records triggered sources, host readable
// - host clears status
// - all transfers are raw 32-bit words, no conversion
// - control word: launch b0, finish b1, idle b2, accept b3, relaunch b7
// - global interrupt enable is bit 0 at 0x04
// - source enables at 0x08: finish b0, accept b1
// - status at 0x0c, writing one toggles a bit
module acr_ctrl_regs
    import acr_pkg::*;
(
    input  wire logic        clk_i,          // core clock
    input  wire logic        arst_n_i,       // async reset, active low
    input  wire logic        psel_i,         // apb select
    input  wire logic        penable_i,      // apb enable
    input  wire logic        pwrite_i,       // apb direction
    input  wire logic [7:0]  paddr_i,        // apb byte address
    input  wire logic [31:0] pwdata_i,       // apb write data
    output logic      [31:0] prdata_o,       // apb read data
    output logic             pready_o,       // apb ready
    output logic             pslverr_o,      // apb error, always low
    output logic             launch_strobe_o, // core launch
    input  wire logic        finish_flag_i,  // core finished
    input  wire logic        quiescent_flag_i, // core idle
    input  wire logic        accept_next_flag_i, // core takes new input
    output logic             proceed_pulse_o, // core proceed
    output logic      [31:0] arg_in_o,       // scalar input operand
    output logic             operand_valid_o, // input operand valid
    input  wire logic        operand_acknowledge_i, // core took input
    input  wire logic [31:0] arg_out_i,      // scalar output operand
    input  wire logic        out_valid_i,    // core output valid
    output logic             out_ack_o,      // output operand ack
    output logic      [63:0] wide_o,         // 64-bit operand
    input  wire logic [2:0]  pack_addr_i,    // core packed array index
    output logic      [7:0]  pack_data_o,    // core packed array element
    output logic             irq_o           // interrupt
);

    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        launch_reg;
    logic        finish_reg;
    logic        relaunch_reg;
    logic        gie_reg;
    logic [1:0]  ier_reg;
    logic [1:0]  isr_reg;
    logic [1:0]  isr_next;
    logic [1:0]  src;
    logic        in_vld_reg;
    logic        in_ack_reg;
    logic        out_vld_reg;
    logic [31:0] out_data_reg;
    logic [31:0] rdata_next;
    logic [31:0] pack_mem [ACR_PACK_WORDS];
    logic [31:0] wide_mem [ACR_WIDE_WORDS];
    logic        hit_pack;
    logic        hit_wide;
    logic [1:0]  widx;
    logic        vidx;

    assign rst_n = rst_sync_reg[1];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // single-cycle access: setup then access, pready high in access phase
    assign acc = psel_i && penable_i;
    assign wr  = acc && pwrite_i;
    assign rd  = acc && !pwrite_i;
    assign hit_pack = (paddr_i >= ACR_PACK_OFS)
                   && (paddr_i < ACR_PACK_OFS + 8'(4 * ACR_PACK_WORDS));
    assign hit_wide = (paddr_i >= ACR_WIDE_OFS)
                   && (paddr_i < ACR_WIDE_OFS + 8'(4 * ACR_WIDE_WORDS));
    assign widx = 2'((paddr_i - ACR_PACK_OFS) >> 2);
    assign vidx = paddr_i[2];

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            if (psel_i && !penable_i && !pwrite_i) begin
                prdata_o <= rdata_next;
            end
        end
    end

    // read data captured in setup so pready and prdata come from flops
    always_comb begin
        rdata_next = 32'h0;
        if (paddr_i == ACR_CTRL_OFS) begin
            rdata_next[ACR_LAUNCH_BIT]   = launch_reg;
            rdata_next[ACR_FINISH_BIT]   = finish_reg;
            rdata_next[ACR_IDLE_BIT]     = quiescent_flag_i;
            rdata_next[ACR_ACCEPT_BIT]   = accept_next_flag_i;
            rdata_next[ACR_RELAUNCH_BIT] = relaunch_reg;
        end else if (paddr_i == ACR_GIE_OFS) begin
            rdata_next[0] = gie_reg;
        end else if (paddr_i == ACR_IER_OFS) begin
            rdata_next[1:0] = ier_reg;
        end else if (paddr_i == ACR_ISR_OFS) begin
            rdata_next[1:0] = isr_reg;
        end else if (paddr_i == ACR_ARG_IN_OFS) begin
            rdata_next = arg_in_o;
        end else if (paddr_i == ACR_ARG_IHS_OFS) begin
            rdata_next[0] = in_vld_reg;
            rdata_next[1] = in_ack_reg;
        end else if (paddr_i == ACR_ARG_OUT_OFS) begin
            rdata_next = out_data_reg;
        end else if (paddr_i == ACR_ARG_OHS_OFS) begin
            rdata_next[0] = out_vld_reg;
        end else if (hit_wide) begin
            rdata_next = wide_mem[vidx];
        end else if (hit_pack) begin
            rdata_next = pack_mem[widx];
        end
    end

    // launch: set by host, held until core accepts or relaunch re-arms
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            launch_reg <= 1'b0;
        end else if (wr && paddr_i == ACR_CTRL_OFS && pwdata_i[ACR_LAUNCH_BIT]) begin
            launch_reg <= 1'b1;
        end else if (accept_next_flag_i) begin
            launch_reg <= relaunch_reg;
        end
    end
    assign launch_strobe_o = launch_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            relaunch_reg <= 1'b0;
        end else if (wr && paddr_i == ACR_CTRL_OFS) begin
            relaunch_reg <= pwdata_i[ACR_RELAUNCH_BIT];
        end
    end

    // finish latched; the clearing read loses to a new finish
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            finish_reg <= 1'b0;
        end else if (finish_flag_i) begin
            finish_reg <= 1'b1;
        end else if (rd && paddr_i == ACR_CTRL_OFS) begin
            finish_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            proceed_pulse_o <= 1'b0;
        end else begin
            proceed_pulse_o <= wr && paddr_i == ACR_PROCEED_OFS && pwdata_i[0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gie_reg <= 1'b0;
            ier_reg <= 2'h0;
        end else begin
            if (wr && paddr_i == ACR_GIE_OFS) begin
                gie_reg <= pwdata_i[0];
            end
            if (wr && paddr_i == ACR_IER_OFS) begin
                ier_reg <= pwdata_i[1:0];
            end
        end
    end

    // sources only exist with the launch strobe, which is always present
    assign src[ACR_SRC_FINISH] = finish_flag_i;
    assign src[ACR_SRC_ACCEPT] = accept_next_flag_i;

    always_comb begin
        isr_next = isr_reg;
        if (wr && paddr_i == ACR_ISR_OFS) begin
            isr_next = isr_reg ^ pwdata_i[1:0];
        end
        isr_next = isr_next | (src & ier_reg);
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            isr_reg <= 2'h0;
            irq_o   <= 1'b0;
        end else begin
            isr_reg <= isr_next;
            irq_o   <= gie_reg && (|isr_reg);
        end
    end

    // input operand: data, valid until core acknowledges
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            arg_in_o   <= ACR_ARG_RST;
            in_vld_reg <= 1'b0;
            in_ack_reg <= 1'b0;
        end else begin
            if (wr && paddr_i == ACR_ARG_IN_OFS) begin
                arg_in_o <= pwdata_i;
            end
            if (wr && paddr_i == ACR_ARG_IHS_OFS && pwdata_i[0]) begin
                in_vld_reg <= 1'b1;
            end else if (operand_acknowledge_i) begin
                in_vld_reg <= 1'b0;
            end
            if (operand_acknowledge_i) begin
                in_ack_reg <= 1'b1;
            end else if (rd && paddr_i == ACR_ARG_IHS_OFS) begin
                in_ack_reg <= 1'b0;
            end
        end
    end
    assign operand_valid_o = in_vld_reg;

    // output operand: captured with valid, valid clears on read
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            out_data_reg <= ACR_ARG_RST;
            out_vld_reg  <= 1'b0;
            out_ack_o    <= 1'b0;
        end else begin
            if (out_valid_i) begin
                out_data_reg <= arg_out_i;
                out_vld_reg  <= 1'b1;
            end else if (rd && paddr_i == ACR_ARG_OHS_OFS) begin
                out_vld_reg <= 1'b0;
            end
            out_ack_o <= wr && paddr_i == ACR_ARG_OHS_OFS && pwdata_i[1];
        end
    end

    // array windows
    genvar g;
    generate
        for (g = 0; g < ACR_PACK_WORDS; g++) begin : g_pack
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pack_mem[g] <= 32'h0;
                end else if (wr && hit_pack && widx == 2'(g)) begin
                    pack_mem[g] <= pwdata_i;
                end
            end
        end
        for (g = 0; g < ACR_WIDE_WORDS; g++) begin : g_wide
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    wide_mem[g] <= 32'h0;
                end else if (wr && hit_wide && vidx == 1'(g)) begin
                    wide_mem[g] <= pwdata_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pack_data_o <= 8'h0;
        end else begin
            // two elements per word, each in its own half-word lane
            pack_data_o <= pack_mem[pack_addr_i[2:1]][{pack_addr_i[0], 4'h0} +: 8];
        end
    end
    assign wide_o = {wide_mem[1], wide_mem[0]};

    gie_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        !gie_reg |=> !irq_o) else $error("irq without global enable");
    isr_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        finish_flag_i && ier_reg[0] |=> isr_reg[0]) else $error("status not set");
    isr_tog_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        wr && paddr_i == ACR_ISR_OFS && pwdata_i[0] && isr_reg[0] && !src[0]
        |=> !isr_reg[0]) else $error("status not toggled");
    launch_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        wr && paddr_i == ACR_CTRL_OFS && pwdata_i[0] |=> launch_strobe_o)
        else $error("launch missing");
    proceed_one_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        proceed_pulse_o |=> !proceed_pulse_o || $past(wr))
        else $error("proceed stuck");
    relaunch_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        relaunch_reg && launch_reg && accept_next_flag_i |=> launch_strobe_o)
        else $error("no relaunch");
    finish_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        finish_flag_i |=> finish_reg) else $error("finish lost");
    ready_next_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        psel_i && !penable_i |=> pready_o && !pslverr_o)
        else $error("no apb answer");

endmodule : acr_ctrl_regs

/* acr_core_model.sv */
`timescale 1ns/100ps
module acr_core_model (
    input  wire logic        clk_i,       // core clock
    input  wire logic        arst_n_i,    // reset, active low
    input  wire logic        launch_i,    // launch strobe
    input  wire logic        op_valid_i,  // input operand valid
    input  wire logic [31:0] arg_in_i,    // input operand
    input  wire logic [3:0]  lat_i,       // answer delay in cycles
    output logic             finish_o,    // run finished
    output logic             quiet_o,     // core idle
    output logic             accept_o,    // ready for next input
    output logic             op_ack_o,    // operand taken
    output logic      [31:0] arg_out_o,   // output operand
    output logic             out_valid_o, // output operand valid
    output logic      [7:0]  runs_o       // launches taken
);
    logic       busy;
    logic [3:0] cnt;
    logic [3:0] acnt;

    // a run starts on a held launch; one idle cycle after each finish
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {busy, finish_o, accept_o, out_valid_o} <= '0;
            quiet_o   <= 1'b1;
            cnt       <= '0;
            runs_o    <= '0;
            arg_out_o <= '0;
        end else begin
            {finish_o, accept_o, out_valid_o} <= '0;
            if (!busy && launch_i && !finish_o) begin
                busy    <= 1'b1;
                quiet_o <= 1'b0;
                cnt     <= lat_i;
                runs_o  <= runs_o + 8'h01;
            end else if (busy && cnt == 4'h0) begin
                busy      <= 1'b0;
                quiet_o   <= 1'b1;
                {finish_o, accept_o, out_valid_o} <= 3'b111;
                arg_out_o <= arg_in_i ^ 32'h5a5a_5a5a;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op_ack_o <= 1'b0;
            acnt     <= '0;
        end else begin
            op_ack_o <= 1'b0;
            if (op_valid_i && !op_ack_o) begin
                if (acnt == lat_i) begin
                    op_ack_o <= 1'b1;
                    acnt     <= '0;
                end else begin
                    acnt <= acnt + 4'h1;
                end
            end
        end
    end
endmodule : acr_core_model

/* testbench.sv */
`timescale 1ns/100ps
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
    import acr_pkg::*;
    typedef struct {string nm; logic [31:0] e; logic [31:0] m;} acr_exp_s;
    logic clk_i = 0, arst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, r1, runs_m;
    logic [31:0] pwdata = 0, d = 0, hi, aout_m, prdata_o, arg_in_o;
    logic [31:0] pk [4];
    logic [2:0]  pa = 0;
    logic [3:0]  lat = 0;
    logic [63:0] wide_o;
    logic [7:0]  pack_data_o;
    logic pready_o, pslverr_o, launch_strobe_o, proceed_pulse_o, operand_valid_o;
    logic out_ack_o, irq_o, fin_m, qui_m, acc_m, ack_m, ov_m;
    acr_exp_s q[$];
    acr_exp_s x;
    int n_errors = 0, checked = 0, cyc = 0, i, n;

    always #5 clk_i = ~clk_i;

    acr_ctrl_regs u_acr_ctrl_regs (.clk_i, .arst_n_i, .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o, .pready_o,
        .pslverr_o, .launch_strobe_o, .finish_flag_i(fin_m), .quiescent_flag_i(qui_m),
        .accept_next_flag_i(acc_m), .proceed_pulse_o, .arg_in_o, .operand_valid_o,
        .operand_acknowledge_i(ack_m), .arg_out_i(aout_m), .out_valid_i(ov_m), .out_ack_o,
        .wide_o, .pack_addr_i(pa), .pack_data_o, .irq_o);
    acr_core_model u_acr_core_model (.clk_i, .arst_n_i, .launch_i(launch_strobe_o),
        .op_valid_i(operand_valid_o), .arg_in_i(arg_in_o), .lat_i(lat), .finish_o(fin_m),
        .quiet_o(qui_m), .accept_o(acc_m), .op_ack_o(ack_m), .arg_out_o(aout_m),
        .out_valid_o(ov_m), .runs_o(runs_m));

    task conclude;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask : wr

    task rd(input string nm, input logic [7:0] a, input logic [31:0] e,
            input logic [31:0] m = 32'hffff_ffff);
        q.push_back('{nm, e, m});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task wfin;
        int k;
        for (k = 0; k < 60 && fin_m !== 1'b1; k++) @(negedge clk_i);
        repeat (3) @(negedge clk_i);
    endtask : wfin

    task cnt_hi(input bit sel);
        n = 0;
        repeat (6) begin
            @(negedge clk_i);
            n += int'(sel ? proceed_pulse_o : out_ack_o);
        end
    endtask : cnt_hi

    // result monitor: each completed read takes the oldest note
    always @(posedge clk_i) begin
        if (psel && penable && pready_o === 1'b1) begin
            `CHK("pslverr", 1'b0, pslverr_o)
            if (!pwrite && q.size() == 0) begin
                n_errors++;
                $display("ERROR read with no expectation");
            end else if (!pwrite) begin
                x = q.pop_front();
                `CHK(x.nm, x.e & x.m, prdata_o & x.m)
            end
        end
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        void'($urandom(32'ha962));
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK("launch", 1'b0, launch_strobe_o)
        `CHK("irq", 1'b0, irq_o)
        rd("ctrl", ACR_CTRL_OFS, 32'h4);
        rd("gie", ACR_GIE_OFS, 32'h0);
        rd("ier", ACR_IER_OFS, 32'h0);
        rd("isr", ACR_ISR_OFS, 32'h0);
        wr(8'h30, 32'hffff_ffff);
        rd("unmapped", 8'h30, 32'h0);
        wr(ACR_GIE_OFS, 32'hffff_ffff);
        rd("gie", ACR_GIE_OFS, 32'h1);
        wr(ACR_IER_OFS, 32'hffff_ffff);
        rd("ier", ACR_IER_OFS, 32'h3);
        d = $urandom;
        lat = 4'($urandom % 8);
        wr(ACR_ARG_IN_OFS, d);
        @(negedge clk_i);
        `CHK("arg_in", d, arg_in_o)
        wr(ACR_CTRL_OFS, 32'h1);
        @(negedge clk_i);
        `CHK("launch", 1'b1, launch_strobe_o)
        wfin();
        `CHK("launch", 1'b0, launch_strobe_o)
        rd("ctrl", ACR_CTRL_OFS, 32'h6, 32'h8f);
        rd("ctrl", ACR_CTRL_OFS, 32'h4, 32'h8f);
        rd("isr", ACR_ISR_OFS, 32'h3);
        @(negedge clk_i);
        `CHK("irq", 1'b1, irq_o)
        rd("arg_out", ACR_ARG_OUT_OFS, d ^ 32'h5a5a_5a5a);
        rd("out_vld", ACR_ARG_OHS_OFS, 32'h1, 32'h1);
        rd("out_vld", ACR_ARG_OHS_OFS, 32'h0, 32'h1);
        wr(ACR_ISR_OFS, 32'h1);
        rd("isr", ACR_ISR_OFS, 32'h2);
        wr(ACR_ISR_OFS, 32'h2);
        rd("isr", ACR_ISR_OFS, 32'h0);
        @(negedge clk_i);
        `CHK("irq", 1'b0, irq_o)
        wr(ACR_GIE_OFS, 32'h0);
        wr(ACR_IER_OFS, 32'h1);
        wr(ACR_CTRL_OFS, 32'h1);
        wfin();
        rd("isr", ACR_ISR_OFS, 32'h1);
        `CHK("irq", 1'b0, irq_o)
        wr(ACR_ISR_OFS, 32'h3);
        rd("isr", ACR_ISR_OFS, 32'h2);
        rd("ctrl", ACR_CTRL_OFS, 32'h6, 32'h8f);
        wr(ACR_ARG_IHS_OFS, 32'h1);
        @(negedge clk_i);
        `CHK("op_valid", 1'b1, operand_valid_o)
        for (i = 0; i < 20 && operand_valid_o === 1'b1; i++) @(negedge clk_i);
        `CHK("op_valid", 1'b0, operand_valid_o)
        rd("op_ack", ACR_ARG_IHS_OFS, 32'h2, 32'h2);
        rd("op_ack", ACR_ARG_IHS_OFS, 32'h0, 32'h2);
        wr(ACR_ARG_OHS_OFS, 32'h2);
        cnt_hi(1'b0);
        `CHK("out_ack", 1, n)
        wr(ACR_PROCEED_OFS, 32'h1);
        cnt_hi(1'b1);
        `CHK("proceed", 1, n)
        d = $urandom;
        hi = $urandom;
        wr(ACR_WIDE_OFS, d);
        wr(ACR_WIDE_OFS + 8'h04, hi);
        @(negedge clk_i);
        `CHK("wide", {hi, d}, wide_o)
        for (i = 0; i < ACR_PACK_WORDS; i++) begin
            pk[i] = $urandom;
            wr(ACR_PACK_OFS + 8'(4 * i), pk[i]);
        end
        for (i = 0; i < ACR_PACK_ELEMS; i++) begin
            @(posedge clk_i);
            pa <= 3'(i);
            repeat (2) @(negedge clk_i);
            `CHK("pack", pk[i / 2][16 * (i % 2) +: 8], pack_data_o)
        end
        r1 = runs_m;
        wr(ACR_CTRL_OFS, 32'h81);
        rd("relaunch", ACR_CTRL_OFS, 32'h80, 32'h80);
        repeat (60) @(negedge clk_i);
        `CHK("relaunch", 1'b1, runs_m >= r1 + 8'h02)
        wr(ACR_CTRL_OFS, 32'h0);
        wfin();
        r1 = runs_m;
        repeat (40) @(negedge clk_i);
        `CHK("stopped", r1, runs_m)
        conclude();
    end
endmodule : testbench
